// ### verilog/cmog_params.svh
// register offsets, field positions and reset values of the clock guard
// assumes inclusion by files that compare against an 4-bit address
`ifndef CMOG_PARAMS_SVH
`define CMOG_PARAMS_SVH

`define CMOG_OFS_CC0   4'h0
`define CMOG_OFS_CC1   4'h1
`define CMOG_OFS_OWC   4'h2
`define CMOG_OFS_PLL   4'h3
`define CMOG_OFS_PCS   4'h4
`define CMOG_OFS_BMC   4'h5
`define CMOG_OFS_WPR   4'ha
`define CMOG_OFS_STAT  4'hb

`define CMOG_CC0_SUBEN   4
`define CMOG_CC0_MSTOP   5
`define CMOG_CC0_DIV8    6
`define CMOG_CC0_SUBSEL  7
`define CMOG_CC1_ALLOFF  0
`define CMOG_CC1_PLLSEL  1
`define CMOG_CC1_DIVLO   6
`define CMOG_CC1_DIVHI   7
`define CMOG_OWC_EN      0
`define CMOG_OWC_RING    1
`define CMOG_OWC_DET     2
`define CMOG_OWC_MSTOPD  3
`define CMOG_OWC_RESP    7
`define CMOG_PLL_EN      7
`define CMOG_WPR_CLK     0
`define CMOG_WPR_MODE    1
`define CMOG_WPR_PORT    2

`define CMOG_CC0_RST  8'h40
`define CMOG_CC1_RST  8'h00
`define CMOG_OWC_RST  8'h00
`define CMOG_PLL_RST  8'h00
`define CMOG_PCS_RST  8'h00
`define CMOG_BMC_RST  8'h00
`define CMOG_WPR_RST  3'h0

`endif

// ### verilog/cmog_pkg.sv
// types shared by the clock guard and its bench
// assumes nothing of its surroundings
package cmog_pkg;

  typedef enum logic [1:0] {
    CMOG_SRC_MAIN = 2'b00,
    CMOG_SRC_PLL  = 2'b01,
    CMOG_SRC_RING = 2'b10,
    CMOG_SRC_SUB  = 2'b11
  } cmog_src_t;

  typedef enum logic [2:0] {
    CMOG_DIV1  = 3'b000,
    CMOG_DIV2  = 3'b001,
    CMOG_DIV4  = 3'b010,
    CMOG_DIV8  = 3'b011,
    CMOG_DIV16 = 3'b100
  } cmog_div_t;

  typedef enum logic [1:0] {
    CMOG_RUN  = 2'b00,
    CMOG_STOP = 2'b01,
    CMOG_HALT = 2'b10
  } cmog_pwr_t;

  typedef struct packed {
    cmog_src_t cpuSrc;
    cmog_src_t periphSrc;
    cmog_div_t cpuDiv;
    logic      mainOscOn;
    logic      subOscOn;
    logic      ringOscOn;
    logic      pllOn;
    logic      stopMode;
  } cmog_clk_ctrl_t;

endpackage

// ### verilog/cmog_clock_guard.sv
// clock mode control, oscillation stop watch and write protection
// assumes one 40 MHz clock, a register master on the same clock, and
// oscillator-alive and wake levels arriving from outside this domain
//
// Added by the designer: the address map and the address-and-strobe port.
`include "cmog_params.svh"
`timescale 1ns/1ps
`default_nettype none

module cmog_clock_guard
  import cmog_pkg::*;
(
  input  wire logic            clock,
  input  wire logic            srst,
  input  wire logic [3:0]      regAddr,
  input  wire logic [7:0]      regWdata,
  input  wire logic            regWrStrobe,
  input  wire logic            regRdStrobe,
  output var  logic [7:0]      regRdata,
  input  wire logic            sysWriteStrobe,
  input  wire logic            mainOscAlive,
  input  wire logic            subOscAlive,
  input  wire logic            wakeRequest,
  output var  cmog_clk_ctrl_t  clkCtrl,
  output var  logic            oscDetectIrq,
  output var  logic            oscDetectReset,
  output var  logic            clockWriteEnable,
  output var  logic            modeWriteEnable,
  output var  logic            portWriteEnable
);

  function automatic cmog_div_t divOf(input logic d8,
                                      input logic [1:0] fld);
    cmog_div_t d;
    d = CMOG_DIV8;
    if (!d8) begin
      case (fld)
        2'b00:   d = CMOG_DIV1;
        2'b01:   d = CMOG_DIV2;
        2'b10:   d = CMOG_DIV4;
        default: d = CMOG_DIV16;
      endcase
    end
    return d;
  endfunction

  // sub select outranks ring select: low-speed keeps the CPU on sub
  function automatic cmog_src_t srcOf(input logic sub, input logic ring,
                                      input logic pll);
    cmog_src_t s;
    if (sub) begin
      s = CMOG_SRC_SUB;
    end else if (ring) begin
      s = CMOG_SRC_RING;
    end else if (pll) begin
      s = CMOG_SRC_PLL;
    end else begin
      s = CMOG_SRC_MAIN;
    end
    return s;
  endfunction

  logic [7:0] cc0Reg;
  logic [7:0] cc0Next;
  logic [7:0] cc1Reg;
  logic [7:0] cc1Next;
  logic [7:0] owcReg;
  logic [7:0] owcNext;
  logic [7:0] pllReg;
  logic [7:0] pcsReg;
  logic [7:0] bmcReg;
  logic [2:0] wpReg;
  logic       lsFallbackReg;
  cmog_pwr_t  pwrReg;
  cmog_pwr_t  pwrNext;

  logic [1:0] mainSyncReg;
  logic [1:0] subSyncReg;
  logic [1:0] wakeSyncReg;
  logic       mainDlyReg;

  logic wrCc0;
  logic wrCc1;
  logic wrOwc;
  logic wrPll;
  logic wrPcs;
  logic wrBmc;
  logic wrWpr;
  logic [7:0] readMux;

  logic       mainAlive;
  logic       subRunning;
  logic       stopEvt;
  logic       reoscEvt;
  logic       detEvt;
  logic       resetResp;
  logic       intResp;
  logic       irqFire;
  logic       stopEnter;
  logic       stopExit;
  cmog_src_t  cpuSrc;
  cmog_div_t  cpuDiv;
  cmog_clk_ctrl_t clkCtrlNext;

  // pin inputs: second stage is read, and for main also the delayed third stage
  always_ff @(posedge clock) begin
    if (srst) begin
      mainSyncReg <= 2'h0;
      subSyncReg  <= 2'h0;
      wakeSyncReg <= 2'h0;
      mainDlyReg  <= 1'h0;
    end else begin
      mainSyncReg <= {mainSyncReg[0], mainOscAlive};
      subSyncReg  <= {subSyncReg[0], subOscAlive};
      wakeSyncReg <= {wakeSyncReg[0], wakeRequest};
      mainDlyReg  <= mainSyncReg[1];
    end
  end

  assign mainAlive  = mainSyncReg[1];
  assign subRunning = cc0Reg[`CMOG_CC0_SUBEN] & subSyncReg[1];

  // address decode
  always_comb begin
    wrCc0 = 1'b0;
    wrCc1 = 1'b0;
    wrOwc = 1'b0;
    wrPll = 1'b0;
    wrPcs = 1'b0;
    wrBmc = 1'b0;
    wrWpr = 1'b0;
    if (!regWrStrobe) begin
      wrCc0 = 1'b0;
    end else if (regAddr == `CMOG_OFS_CC0) begin
      wrCc0 = wpReg[`CMOG_WPR_CLK];
    end else if (regAddr == `CMOG_OFS_CC1) begin
      wrCc1 = wpReg[`CMOG_WPR_CLK];
    end else if (regAddr == `CMOG_OFS_OWC) begin
      wrOwc = wpReg[`CMOG_WPR_CLK];
    end else if (regAddr == `CMOG_OFS_PLL) begin
      wrPll = wpReg[`CMOG_WPR_CLK];
    end else if (regAddr == `CMOG_OFS_PCS) begin
      wrPcs = wpReg[`CMOG_WPR_CLK];
    end else if (regAddr == `CMOG_OFS_BMC) begin
      wrBmc = wpReg[`CMOG_WPR_CLK];
    end else if (regAddr == `CMOG_OFS_WPR) begin
      wrWpr = 1'b1;
    end
  end

  assign cpuSrc = srcOf(cc0Reg[`CMOG_CC0_SUBSEL], owcReg[`CMOG_OWC_RING],
                        cc1Reg[`CMOG_CC1_PLLSEL]);
  assign cpuDiv = divOf(cc0Reg[`CMOG_CC0_DIV8],
                        {cc1Reg[`CMOG_CC1_DIVHI], cc1Reg[`CMOG_CC1_DIVLO]});

  // detection: edges of the synchronised alive level
  assign stopEvt   = mainDlyReg & ~mainAlive;
  assign reoscEvt  = ~mainDlyReg & mainAlive;
  assign detEvt    = owcReg[`CMOG_OWC_EN] & (stopEvt | reoscEvt)
                     & (pwrReg == CMOG_RUN);
  assign resetResp = detEvt & ~owcReg[`CMOG_OWC_RESP];
  assign intResp   = detEvt & owcReg[`CMOG_OWC_RESP];
  assign irqFire   = intResp & ~owcReg[`CMOG_OWC_DET];
  assign stopEnter = (pwrReg == CMOG_RUN) & wrCc1
                     & regWdata[`CMOG_CC1_ALLOFF] & ~resetResp;
  assign stopExit  = (pwrReg == CMOG_STOP) & wakeSyncReg[1];

  // power state
  always_comb begin
    pwrNext = pwrReg;
    case (pwrReg)
      CMOG_RUN: begin
        if (resetResp) begin
          pwrNext = CMOG_HALT;
        end else if (stopEnter) begin
          pwrNext = CMOG_STOP;
        end
      end
      CMOG_STOP: begin
        if (stopExit) begin
          pwrNext = CMOG_RUN;
        end
      end
      CMOG_HALT: begin
        pwrNext = CMOG_HALT;
      end
      default: begin
        pwrNext = CMOG_RUN;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pwrReg <= CMOG_RUN;
    end else begin
      pwrReg <= pwrNext;
    end
  end

  // clock control 0
  always_comb begin
    cc0Next = cc0Reg;
    if (wrCc0) begin
      cc0Next = regWdata;
      if (regWdata[`CMOG_CC0_SUBSEL] & ~cc0Reg[`CMOG_CC0_SUBSEL]
          & ~subRunning) begin
        cc0Next[`CMOG_CC0_SUBSEL] = 1'b0;
      end
      if (regWdata[`CMOG_CC0_MSTOP]) begin
        cc0Next[`CMOG_CC0_DIV8] = 1'b1;
      end
    end
    if (stopEnter | stopExit) begin
      cc0Next[`CMOG_CC0_DIV8] = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cc0Reg <= `CMOG_CC0_RST;
    end else begin
      cc0Reg <= cc0Next;
    end
  end

  // clock control 1; all-clocks-off reads back one only inside stop
  always_comb begin
    cc1Next = cc1Reg;
    if (wrCc1) begin
      cc1Next = regWdata;
    end
    if (stopExit) begin
      cc1Next[`CMOG_CC1_ALLOFF] = 1'b0;
    end
    if (resetResp) begin
      cc1Next[`CMOG_CC1_ALLOFF] = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cc1Reg <= `CMOG_CC1_RST;
    end else begin
      cc1Reg <= cc1Next;
    end
  end

  // oscillation watch control: hardware sets win over software clears
  always_comb begin
    owcNext = owcReg;
    if (wrOwc) begin
      owcNext[`CMOG_OWC_EN]   = regWdata[`CMOG_OWC_EN];
      owcNext[`CMOG_OWC_RING] = regWdata[`CMOG_OWC_RING];
      owcNext[`CMOG_OWC_RESP] = regWdata[`CMOG_OWC_RESP];
      if (!regWdata[`CMOG_OWC_DET]) begin
        owcNext[`CMOG_OWC_DET] = 1'b0;
      end
    end
    if (intResp & stopEvt) begin
      owcNext[`CMOG_OWC_MSTOPD] = 1'b1;
      if (cpuSrc == CMOG_SRC_MAIN) begin
        owcNext[`CMOG_OWC_RING] = 1'b1;
      end
    end
    if (intResp & reoscEvt) begin
      owcNext[`CMOG_OWC_MSTOPD] = 1'b0;
    end
    if (irqFire) begin
      owcNext[`CMOG_OWC_DET] = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      owcReg <= `CMOG_OWC_RST;
    end else begin
      owcReg <= owcNext;
    end
  end

  // low-speed fallback: peripherals on ring, CPU stays on sub
  always_ff @(posedge clock) begin
    if (srst) begin
      lsFallbackReg <= 1'b0;
    end else if (intResp & stopEvt & (cpuSrc == CMOG_SRC_SUB)) begin
      lsFallbackReg <= 1'b1;
    end else if ((intResp & reoscEvt) | ~cc0Reg[`CMOG_CC0_SUBSEL]) begin
      lsFallbackReg <= 1'b0;
    end
  end

  // other protected clock registers
  always_ff @(posedge clock) begin
    if (srst) begin
      pllReg <= `CMOG_PLL_RST;
      pcsReg <= `CMOG_PCS_RST;
      bmcReg <= `CMOG_BMC_RST;
    end else begin
      if (wrPll) begin
        pllReg <= regWdata;
      end
      if (wrPcs) begin
        pcsReg <= regWdata;
      end
      if (wrBmc) begin
        bmcReg <= regWdata;
      end
    end
  end

  // protect bits; the port bit is one-shot
  always_ff @(posedge clock) begin
    if (srst) begin
      wpReg <= `CMOG_WPR_RST;
    end else if (wrWpr) begin
      wpReg <= regWdata[2:0];
    end else if (regWrStrobe | sysWriteStrobe) begin
      wpReg[`CMOG_WPR_PORT] <= 1'b0;
    end
  end

  // clock outputs
  always_comb begin
    clkCtrlNext.cpuSrc    = cpuSrc;
    // divider taken from next state so stop entry shows divide-by-8 at once
    clkCtrlNext.cpuDiv    = divOf(cc0Next[`CMOG_CC0_DIV8],
                                  {cc1Next[`CMOG_CC1_DIVHI],
                                   cc1Next[`CMOG_CC1_DIVLO]});
    clkCtrlNext.stopMode  = (pwrNext != CMOG_RUN);
    if (owcNext[`CMOG_OWC_RING] | lsFallbackReg) begin
      clkCtrlNext.periphSrc = CMOG_SRC_RING;
    end else if (cc1Reg[`CMOG_CC1_PLLSEL]) begin
      clkCtrlNext.periphSrc = CMOG_SRC_PLL;
    end else begin
      clkCtrlNext.periphSrc = CMOG_SRC_MAIN;
    end
    clkCtrlNext.mainOscOn = ~cc0Reg[`CMOG_CC0_MSTOP]
                            & ~clkCtrlNext.stopMode;
    clkCtrlNext.subOscOn  = cc0Reg[`CMOG_CC0_SUBEN]
                            & ~clkCtrlNext.stopMode;
    clkCtrlNext.ringOscOn = (owcNext[`CMOG_OWC_RING] | lsFallbackReg)
                            & ~clkCtrlNext.stopMode;
    clkCtrlNext.pllOn     = pllReg[`CMOG_PLL_EN] & ~clkCtrlNext.stopMode;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      clkCtrl <= '0;
    end else begin
      clkCtrl <= clkCtrlNext;
    end
  end

  // response outputs; halt level holds until srst
  always_ff @(posedge clock) begin
    if (srst) begin
      oscDetectIrq   <= 1'b0;
      oscDetectReset <= 1'b0;
    end else begin
      oscDetectIrq   <= irqFire;
      oscDetectReset <= (pwrNext == CMOG_HALT);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      clockWriteEnable <= 1'b0;
      modeWriteEnable  <= 1'b0;
      portWriteEnable  <= 1'b0;
    end else begin
      clockWriteEnable <= wpReg[`CMOG_WPR_CLK];
      modeWriteEnable  <= wpReg[`CMOG_WPR_MODE];
      portWriteEnable  <= wpReg[`CMOG_WPR_PORT];
    end
  end

  // read path
  always_comb begin
    readMux = 8'h00;
    if (regAddr == `CMOG_OFS_CC0) begin
      readMux = cc0Reg;
    end else if (regAddr == `CMOG_OFS_CC1) begin
      readMux = cc1Reg;
    end else if (regAddr == `CMOG_OFS_OWC) begin
      readMux = {owcReg[7], 3'h0, owcReg[3:0]};
    end else if (regAddr == `CMOG_OFS_PLL) begin
      readMux = pllReg;
    end else if (regAddr == `CMOG_OFS_PCS) begin
      readMux = pcsReg;
    end else if (regAddr == `CMOG_OFS_BMC) begin
      readMux = bmcReg;
    end else if (regAddr == `CMOG_OFS_WPR) begin
      readMux = {5'h00, wpReg};
    end else if (regAddr == `CMOG_OFS_STAT) begin
      readMux = {pwrReg, mainAlive, cpuSrc, cpuDiv};
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      regRdata <= 8'h00;
    end else if (regRdStrobe) begin
      regRdata <= readMux;
    end else begin
      regRdata <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// ### dv/cmog_clock_guard_asserts.sv
// port checker for the clock guard
// assumes one clock domain and a bind onto cmog_clock_guard
`include "cmog_params.svh"
`timescale 1ns/1ps
`default_nettype none

module cmog_clock_guard_asserts
  import cmog_pkg::*;
(
  input wire logic           clock,
  input wire logic           srst,
  input wire logic [3:0]     regAddr,
  input wire logic           regWrStrobe,
  input wire logic           sysWriteStrobe,
  input wire logic           mainOscAlive,
  input wire cmog_clk_ctrl_t clkCtrl,
  input wire logic           oscDetectIrq,
  input wire logic           oscDetectReset,
  input wire logic           portWriteEnable
);
  logic       alivePrev_reg;
  logic [3:0] sinceEdge_reg;

  // saturating age of the last pin edge; sync delay is a few cycles
  always_ff @(posedge clock) begin
    alivePrev_reg <= mainOscAlive;
    if (srst) begin
      sinceEdge_reg <= 4'hf;
    end else if (mainOscAlive != alivePrev_reg) begin
      sinceEdge_reg <= 4'h0;
    end else if (sinceEdge_reg != 4'hf) begin
      sinceEdge_reg <= sinceEdge_reg + 4'h1;
    end
  end

  default clocking dc @(posedge clock); endclocking
  default disable iff (srst);

  chk_irq_one_cycle:
    assert property (oscDetectIrq |=> !oscDetectIrq)
    else $error("detect irq longer than one cycle");
  chk_irq_after_edge:
    assert property (oscDetectIrq |-> sinceEdge_reg < 4'h8)
    else $error("detect irq without a recent pin edge");
  chk_halt_sticky:
    assert property (oscDetectReset |=> oscDetectReset)
    else $error("halt level dropped before reset");
  chk_halt_no_irq:
    assert property (oscDetectReset |-> !oscDetectIrq)
    else $error("irq raised under reset response");
  chk_stop_entry:
    assert property ($rose(clkCtrl.stopMode) |-> clkCtrl.cpuDiv == CMOG_DIV8
      && !clkCtrl.mainOscOn && !clkCtrl.subOscOn && !clkCtrl.ringOscOn
      && !clkCtrl.pllOn)
    else $error("stop entry left a clock running");
  chk_stop_exit_div8:
    assert property ($fell(clkCtrl.stopMode) && !oscDetectReset
      |-> clkCtrl.cpuDiv == CMOG_DIV8)
    else $error("stop exit without divide by 8");
  chk_mstop_div8:
    assert property ($fell(clkCtrl.mainOscOn) && !clkCtrl.stopMode
      && !oscDetectReset |-> clkCtrl.cpuDiv == CMOG_DIV8)
    else $error("main stop without divide by 8");
  chk_oneshot_clear:
    assert property (portWriteEnable && (sysWriteStrobe || regWrStrobe
      && regAddr != `CMOG_OFS_WPR) |=> ##1 !portWriteEnable)
    else $error("port enable survived a write");

  cov_irq: cover property (oscDetectIrq);
  cov_stop: cover property ($rose(clkCtrl.stopMode));
  cov_halt: cover property ($rose(oscDetectReset));
  cov_oneshot: cover property ($fell(portWriteEnable));
endmodule

bind cmog_clock_guard cmog_clock_guard_asserts chk (
  .clock(clock), .srst(srst), .regAddr(regAddr), .regWrStrobe(regWrStrobe),
  .sysWriteStrobe(sysWriteStrobe), .mainOscAlive(mainOscAlive),
  .clkCtrl(clkCtrl), .oscDetectIrq(oscDetectIrq),
  .oscDetectReset(oscDetectReset), .portWriteEnable(portWriteEnable));

`default_nettype wire

// ### dv/test_clock_mode_osc_stop_guard.sv
// self-checking bench for the clock guard
// assumes the guard alone on a 40 MHz clock, bench drives every port
`include "cmog_params.svh"
`timescale 1ns/1ps
`default_nettype none

module test_clock_mode_osc_stop_guard
  import cmog_pkg::*;
;
  logic           clock = 1'b0;
  logic           srst = 1'b1;
  logic [3:0]     regAddr = 4'h0;
  logic [7:0]     regWdata = 8'h00;
  logic           regWrStrobe = 1'b0;
  logic           regRdStrobe = 1'b0;
  logic [7:0]     regRdata;
  logic           sysWriteStrobe = 1'b0;
  logic           mainOscAlive = 1'b1;
  logic           subOscAlive = 1'b0;
  logic           wakeRequest = 1'b0;
  cmog_clk_ctrl_t clkCtrl;
  logic           oscDetectIrq;
  logic           oscDetectReset;
  logic           clockWriteEnable;
  logic           modeWriteEnable;
  logic           portWriteEnable;
  int             miscompares = 0;
  int             num_checks = 0;
  cmog_div_t      divs[4] = '{CMOG_DIV1, CMOG_DIV2, CMOG_DIV4, CMOG_DIV16};

  cmog_clock_guard uut (
    .clock(clock), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
    .regRdata(regRdata), .sysWriteStrobe(sysWriteStrobe),
    .mainOscAlive(mainOscAlive), .subOscAlive(subOscAlive),
    .wakeRequest(wakeRequest), .clkCtrl(clkCtrl),
    .oscDetectIrq(oscDetectIrq), .oscDetectReset(oscDetectReset),
    .clockWriteEnable(clockWriteEnable), .modeWriteEnable(modeWriteEnable),
    .portWriteEnable(portWriteEnable));

  always #12.5 clock = ~clock;

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrStrobe <= 1'b1;
    @(posedge clock);
    regWrStrobe <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge clock);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge clock);
    regRdStrobe <= 1'b0;
    #1 chk(n, regRdata, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic pin(input logic v);
    @(posedge clock);
    mainOscAlive <= v;
  endtask

  // irq is a one-cycle pulse, so every cycle of the window is looked at
  task automatic wirq(input logic e, input string n);
    logic seen;
    seen = 1'b0;
    repeat (12) begin
      @(posedge clock);
      #1 if (oscDetectIrq === 1'b1) seen = 1'b1;
    end
    chk(n, {7'h0, seen}, {7'h0, e});
  endtask

  task automatic t_reset();
    chk("cpu source", clkCtrl.cpuSrc, CMOG_SRC_MAIN);
    chk("cpu divider", clkCtrl.cpuDiv, CMOG_DIV8);
    chk("main osc on", clkCtrl.mainOscOn, 1'b1);
    rd(`CMOG_OFS_CC0, `CMOG_CC0_RST, "clock ctrl 0");
    rd(`CMOG_OFS_WPR, 8'h00, "protect reg");
    rd(4'hf, 8'h00, "unmapped");
    wr(`CMOG_OFS_CC0, 8'h00);
    rd(`CMOG_OFS_CC0, `CMOG_CC0_RST, "locked write");
  endtask

  task automatic t_protect();
    wr(`CMOG_OFS_WPR, 8'h01);
    cyc(2);
    chk("clock enable", clockWriteEnable, 1'b1);
    chk("mode enable", modeWriteEnable, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(`CMOG_OFS_CC0, 8'h00);
      wr(`CMOG_OFS_CC1, 8'(i << 6));
      cyc(2);
      chk("div field", clkCtrl.cpuDiv, divs[i]);
    end
    wr(`CMOG_OFS_CC0, 8'h10);
    cyc(2);
    chk("sub osc on", clkCtrl.subOscOn, 1'b1);
    chk("div kept", clkCtrl.cpuDiv, CMOG_DIV16);
    wr(`CMOG_OFS_CC1, 8'h00);
    wr(`CMOG_OFS_CC0, 8'h40);
  endtask

  task automatic t_oneshot();
    wr(`CMOG_OFS_WPR, 8'h07);
    cyc(2);
    chk("port enable", portWriteEnable, 1'b1);
    wr(`CMOG_OFS_PCS, 8'h5a);
    cyc(2);
    chk("port cleared", portWriteEnable, 1'b0);
    chk("mode kept", modeWriteEnable, 1'b1);
    rd(`CMOG_OFS_PCS, 8'h5a, "periph select");
    wr(`CMOG_OFS_WPR, 8'h05);
    cyc(2);
    @(posedge clock);
    sysWriteStrobe <= 1'b1;
    @(posedge clock);
    sysWriteStrobe <= 1'b0;
    cyc(2);
    chk("port cleared sys", portWriteEnable, 1'b0);
    wr(`CMOG_OFS_WPR, 8'h01);
  endtask

  task automatic t_ring_sub();
    wr(`CMOG_OFS_OWC, 8'h02);
    cyc(2);
    chk("ring source", clkCtrl.cpuSrc, CMOG_SRC_RING);
    wr(`CMOG_OFS_OWC, 8'h00);
    wr(`CMOG_OFS_CC0, 8'hc0);
    cyc(2);
    chk("no sub clock", clkCtrl.cpuSrc, CMOG_SRC_MAIN);
    @(posedge clock);
    subOscAlive <= 1'b1;
    wr(`CMOG_OFS_CC0, 8'h50);
    cyc(4);
    wr(`CMOG_OFS_CC0, 8'hd0);
    cyc(2);
    chk("sub source", clkCtrl.cpuSrc, CMOG_SRC_SUB);
    wr(`CMOG_OFS_OWC, 8'h81);
    pin(1'b0);
    wirq(1'b1, "low speed irq");
    chk("cpu on sub", clkCtrl.cpuSrc, CMOG_SRC_SUB);
    chk("periph on ring", clkCtrl.periphSrc, CMOG_SRC_RING);
    chk("ring on", clkCtrl.ringOscOn, 1'b1);
    pin(1'b1);
    cyc(8);
    wr(`CMOG_OFS_OWC, 8'h00);
    wr(`CMOG_OFS_CC0, 8'h40);
  endtask

  task automatic t_main_det();
    wr(`CMOG_OFS_OWC, 8'h81);
    pin(1'b0);
    wirq(1'b1, "stop irq");
    chk("fallback source", clkCtrl.cpuSrc, CMOG_SRC_RING);
    rd(`CMOG_OFS_OWC, 8'h8f, "stop flags");
    wr(`CMOG_OFS_OWC, 8'h83);
    pin(1'b1);
    wirq(1'b1, "restart irq");
    rd(`CMOG_OFS_OWC, 8'h87, "restart flags");
    pin(1'b0);
    wirq(1'b0, "blocked irq");
    rd(`CMOG_OFS_OWC, 8'h8f, "blocked flags");
    wr(`CMOG_OFS_OWC, 8'h02);
    pin(1'b1);
    wirq(1'b0, "disabled irq");
    wr(`CMOG_OFS_OWC, 8'h00);
    cyc(2);
    chk("main source", clkCtrl.cpuSrc, CMOG_SRC_MAIN);
  endtask

  task automatic t_pll();
    wr(`CMOG_OFS_PLL, 8'h80);
    wr(`CMOG_OFS_CC1, 8'h02);
    cyc(2);
    chk("pll source", clkCtrl.cpuSrc, CMOG_SRC_PLL);
    chk("pll on", clkCtrl.pllOn, 1'b1);
    rd(`CMOG_OFS_STAT, 8'h2b, "status");
    wr(`CMOG_OFS_OWC, 8'h81);
    pin(1'b0);
    wirq(1'b1, "pll stop irq");
    rd(`CMOG_OFS_OWC, 8'h8d, "pll stop flags");
    wr(`CMOG_OFS_OWC, 8'h80);
    pin(1'b1);
    cyc(8);
    wr(`CMOG_OFS_CC1, 8'h00);
    wr(`CMOG_OFS_PLL, 8'h00);
  endtask

  task automatic t_stop();
    wr(`CMOG_OFS_CC0, 8'h20);
    cyc(2);
    chk("main stop div8", clkCtrl.cpuDiv, CMOG_DIV8);
    chk("main osc off", clkCtrl.mainOscOn, 1'b0);
    wr(`CMOG_OFS_CC0, 8'h00);
    wr(`CMOG_OFS_CC1, 8'h01);
    cyc(2);
    chk("stop mode", clkCtrl.stopMode, 1'b1);
    chk("stop div8", clkCtrl.cpuDiv, CMOG_DIV8);
    @(posedge clock);
    wakeRequest <= 1'b1;
    for (int i = 0; i < 10 && clkCtrl.stopMode !== 1'b0; i++) cyc(1);
    @(posedge clock);
    wakeRequest <= 1'b0;
    #1;
    chk("stop exit", clkCtrl.stopMode, 1'b0);
    chk("exit div8", clkCtrl.cpuDiv, CMOG_DIV8);
    rd(`CMOG_OFS_CC1, 8'h00, "clocks off bit");
  endtask

  task automatic t_halt();
    wr(`CMOG_OFS_OWC, 8'h01);
    pin(1'b0);
    for (int i = 0; i < 12 && oscDetectReset !== 1'b1; i++) cyc(1);
    chk("halt", oscDetectReset, 1'b1);
    cyc(6);
    chk("halt held", oscDetectReset, 1'b1);
    pin(1'b1);
    srst <= 1'b1;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    cyc(2);
    chk("halt cleared", oscDetectReset, 1'b0);
  endtask

  initial begin
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    cyc(2);
    t_reset();
    t_protect();
    t_oneshot();
    t_ring_sub();
    t_main_det();
    t_pll();
    t_stop();
    t_halt();
    close_out();
  end

  // whole run is well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clock);
    miscompares++;
    close_out();
  end
endmodule

`default_nettype wire
